// ### rtl/tadc_defs.svh
// constants of the tracking converter: widths, pin slots, counts, resets
`ifndef TADC_DEFS_SVH
`define TADC_DEFS_SVH

// -------------------------------------------------------------
// widths and counts
// -------------------------------------------------------------
`define TADC_WORD_W 10
`define TADC_FRAME_W 11
`define TADC_BITS_LONG 4'hB
`define TADC_BITS_SHORT 4'h9
`define TADC_TXCLK_MAX_HZ 1000000
`define TADC_SYS_HZ 25000000

// -------------------------------------------------------------
// slots of the synchronised input vector
// -------------------------------------------------------------
`define TADC_SI_W 13
`define TADC_SI_CNTCLK 0
`define TADC_SI_UP 1
`define TADC_SI_LOAD 2
`define TADC_SI_XMIT 3
`define TADC_SI_XCLK 4
`define TADC_SI_EVEN 5
`define TADC_SI_LEN8 6
`define TADC_SI_SHIFT 7
`define TADC_SI_PLOAD 8
`define TADC_SI_STROBE 9
`define TADC_SI_SDIN 10
`define TADC_SI_CODE 11
`define TADC_SI_INV 12

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define TADC_RST_WORD 10'h000
`define TADC_RST_FRAME 11'h000
// shift clock idles high, so its stages start high: no false edge
`define TADC_RST_SYNC 13'h0080
`define TADC_RST_LEFT 4'h0

`endif

// ### rtl/tadc_pkg.sv
// types shared by the tracking converter modules
package tadc_pkg;

  typedef logic [9:0] tadc_word_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ARM = 2'b01,
    TX_SEND = 2'b10
  } tadc_tx_e;

endpackage

// ### rtl/tadc_dac_if.sv
// link between the tracking logic and the stochastic converter core
`timescale 1ns/1ps
interface tadc_dac_if;
  logic shift_rise;
  logic ser_bit;
  logic par_load;
  logic strobe;
  logic code_twos;
  logic invert;
  tadc_pkg::tadc_word_t par_word;
  logic pulse;

  modport drv (
    output shift_rise,
    output ser_bit,
    output par_load,
    output strobe,
    output code_twos,
    output invert,
    output par_word,
    input pulse
  );

  modport core (
    input shift_rise,
    input ser_bit,
    input par_load,
    input strobe,
    input code_twos,
    input invert,
    input par_word,
    output pulse
  );
endinterface

// ### rtl/tadc_sync.sv
// two-stage synchroniser for a vector of outside levels
`timescale 1ns/1ps
`include "tadc_defs.svh"
module tadc_sync #(
  parameter int W = `TADC_SI_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, high
  input wire logic [W-1:0] i_d, // raw levels
  output logic [W-1:0] o_q // synchronised levels
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule

// ### rtl/tadc_dac.sv
// stochastic converter core: input register, cycling counter, comparator
`timescale 1ns/1ps
`include "tadc_defs.svh"
module tadc_dac (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, high
  tadc_dac_if.core bus // controls in, pulse out
);
  tadc_pkg::tadc_word_t shift_ff;
  tadc_pkg::tadc_word_t data_ff;
  tadc_pkg::tadc_word_t seq_ff;
  tadc_pkg::tadc_word_t eff_word;
  tadc_pkg::tadc_word_t cmp_word;
  tadc_pkg::tadc_word_t nxt_shift;
  logic pulse_ff;

  // bit reversal spreads the high phase over the cycle
  function automatic tadc_pkg::tadc_word_t tadc_rev(
    input tadc_pkg::tadc_word_t w
  );
    tadc_pkg::tadc_word_t r;
    begin
      for (int i = 0; i < `TADC_WORD_W; i++) begin
        r[i] = w[`TADC_WORD_W-1-i];
      end
      return r;
    end
  endfunction

  // -------------------------------------------------------------
  // serial shift register and data register
  // -------------------------------------------------------------
  // msb enters first and moves up
  assign nxt_shift = {shift_ff[8:0], bus.ser_bit};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_ff <= `TADC_RST_WORD;
    end else if (bus.shift_rise) begin
      shift_ff <= nxt_shift;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_ff <= `TADC_RST_WORD;
    end else if (bus.par_load) begin
      data_ff <= bus.par_word;
    end else if (bus.strobe) begin
      data_ff <= shift_ff;
    end
  end

  // -------------------------------------------------------------
  // cycling counter and comparator
  // -------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seq_ff <= `TADC_RST_WORD;
    end else begin
      seq_ff <= seq_ff + 10'h001;
    end
  end

  // twos complement: flip the msb so 1000000000 maps to zero
  assign eff_word = data_ff ^ {bus.code_twos, 9'h000};
  assign cmp_word = tadc_rev(seq_ff);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= (eff_word > cmp_word) ^ bus.invert;
    end
  end

  assign bus.pulse = pulse_ff;
endmodule

// ### rtl/tadc_top.sv
// tracking converter: up/down counter, serial transmitter, core link
`timescale 1ns/1ps
`include "tadc_defs.svh"
// Overview of operation
// - code input low binary, high twos complement
// - twos complement flips msb before conversion
// - ten parallel lines, line one is msb
// - serial bit taken on shift clock rise
// - parallel load high copies lines to register
// - strobe high copies shifted word, low holds
// - serial word enters msb first
// - invert input high inverts pulse output
// - pulse high when register exceeds cycling counter
// - ten bit up/down counter drives parallel outputs
// - direction high counts up, low down
// - count blocked on turn, load, or limit
// - load copies counter; load during send waits
// - data available rises on load, falls after send
// - transmit pulse starts send on transmitter clock
// - eight or ten data bits plus parity
// - word length input high sends eight bits
// - parity input high even, low odd
// - nine or eleven chain pulses per send
// - cascade high one clock at send end
module tadc_top (
  input wire logic i_clk, // system clock, 25 MHz
  input wire logic i_rst, // async reset, high
  input wire logic i_cnt_clk, // tracking counter clock
  input wire logic i_up, // count direction, high up
  input wire logic i_load, // load transmitter pulse
  input wire logic i_xmit, // transmit request pulse
  input wire logic i_tx_clk, // transmitter clock
  input wire logic i_even_par, // high even parity
  input wire logic i_len8, // high eight bit frame
  input wire logic i_shift_clk, // core serial shift clock
  input wire logic i_par_load, // core parallel load
  input wire logic i_strobe, // core serial strobe
  input wire logic i_ser_din, // core serial data
  input wire logic i_code_twos, // high twos complement
  input wire logic i_invert, // high inverts pulse output
  output logic [9:0] o_track, // tracking counter value
  output logic o_ser_out, // transmitted serial data
  output logic o_pulse_chain, // receiver clock pulses
  output logic o_data_avail, // transmitter holds data
  output logic o_cascade, // end of send, one tx clock
  output logic o_dac_pulse // stochastic pulse output
);

  // -------------------------------------------------------------
  // input synchronisation and edge detection
  // -------------------------------------------------------------
  logic [`TADC_SI_W-1:0] raw_in;
  logic [`TADC_SI_W-1:0] sq;
  logic [`TADC_SI_W-1:0] sq_d_ff;
  logic [`TADC_SI_W-1:0] rise;
  logic [`TADC_SI_W-1:0] fall;

  assign raw_in[`TADC_SI_CNTCLK] = i_cnt_clk;
  assign raw_in[`TADC_SI_UP] = i_up;
  assign raw_in[`TADC_SI_LOAD] = i_load;
  assign raw_in[`TADC_SI_XMIT] = i_xmit;
  assign raw_in[`TADC_SI_XCLK] = i_tx_clk;
  assign raw_in[`TADC_SI_EVEN] = i_even_par;
  assign raw_in[`TADC_SI_LEN8] = i_len8;
  assign raw_in[`TADC_SI_SHIFT] = i_shift_clk;
  assign raw_in[`TADC_SI_PLOAD] = i_par_load;
  assign raw_in[`TADC_SI_STROBE] = i_strobe;
  assign raw_in[`TADC_SI_SDIN] = i_ser_din;
  assign raw_in[`TADC_SI_CODE] = i_code_twos;
  assign raw_in[`TADC_SI_INV] = i_invert;

  tadc_sync #(
    .W(`TADC_SI_W),
    .RST_VAL(`TADC_RST_SYNC)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d(raw_in),
    .o_q(sq)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sq_d_ff <= `TADC_RST_SYNC;
    end else begin
      sq_d_ff <= sq;
    end
  end

  assign rise = sq & ~sq_d_ff;
  assign fall = ~sq & sq_d_ff;

  // -------------------------------------------------------------
  // shared transmitter state
  // -------------------------------------------------------------
  tadc_pkg::tadc_tx_e tx_state_ff;
  tadc_pkg::tadc_word_t cnt_ff;
  tadc_pkg::tadc_word_t hold_ff;
  logic [`TADC_FRAME_W-1:0] frame_ff;
  logic [3:0] left_ff;
  logic pend_ff;
  logic avail_ff;
  logic ser_ff;
  logic chain_ff;
  logic casc_ff;
  logic load_do;
  logic tx_shift;
  logic tx_end;
  logic [`TADC_FRAME_W-1:0] frame_new;
  logic xr;
  logic xf;

  assign xr = rise[`TADC_SI_XCLK];
  assign xf = fall[`TADC_SI_XCLK];

  // a bit moves on only at the fall that ends its own chain pulse
  assign tx_shift = (tx_state_ff == tadc_pkg::TX_SEND) && xf && chain_ff;

  // last bit leaves at the falling edge after its chain pulse
  assign tx_end = tx_shift && (left_ff == 4'h1);

  // a load never disturbs a frame on the wire
  assign load_do = (rise[`TADC_SI_LOAD] | pend_ff) &&
                   (tx_state_ff != tadc_pkg::TX_SEND);

  // -------------------------------------------------------------
  // tracking up/down counter
  // -------------------------------------------------------------
  logic dir_ff;
  logic dir_chg_ff;
  logic at_limit;
  logic cnt_step;

  // stop at the end the counter is heading for, so it never wraps
  assign at_limit = sq[`TADC_SI_UP] ? (cnt_ff == 10'h3FF)
                                    : (cnt_ff == 10'h000);

  assign cnt_step = rise[`TADC_SI_CNTCLK] && !dir_chg_ff &&
                    (sq[`TADC_SI_UP] == dir_ff) &&
                    !load_do && !at_limit;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dir_ff <= 1'b1;
    end else begin
      dir_ff <= sq[`TADC_SI_UP];
    end
  end

  // first count edge after a turn is swallowed; a new turn wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dir_chg_ff <= 1'b0;
    end else if (sq[`TADC_SI_UP] != dir_ff) begin
      dir_chg_ff <= 1'b1;
    end else if (rise[`TADC_SI_CNTCLK]) begin
      dir_chg_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= `TADC_RST_WORD;
    end else if (cnt_step && sq[`TADC_SI_UP]) begin
      cnt_ff <= cnt_ff + 10'h001;
    end else if (cnt_step) begin
      cnt_ff <= cnt_ff - 10'h001;
    end
  end

  // -------------------------------------------------------------
  // load into the transmitter
  // -------------------------------------------------------------
  // a load that meets a frame in flight waits for the frame's end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_ff <= 1'b0;
    end else if (rise[`TADC_SI_LOAD] &&
                 tx_state_ff == tadc_pkg::TX_SEND) begin
      pend_ff <= 1'b1;
    end else if (load_do) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_ff <= `TADC_RST_WORD;
    end else if (load_do) begin
      hold_ff <= cnt_ff;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      avail_ff <= 1'b0;
    end else if (load_do) begin
      avail_ff <= 1'b1;
    end else if (tx_end) begin
      avail_ff <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // frame builder
  // -------------------------------------------------------------
  function automatic logic tadc_parity(
    input tadc_pkg::tadc_word_t w,
    input logic len8,
    input logic even
  );
    logic odd_ones;
    begin
      odd_ones = len8 ? (^w[9:2]) : (^w);
      return even ? odd_ones : ~odd_ones;
    end
  endfunction

  // data msb at the top, parity right after the last data bit
  function automatic logic [`TADC_FRAME_W-1:0] tadc_frame(
    input tadc_pkg::tadc_word_t w,
    input logic len8,
    input logic even
  );
    logic p;
    begin
      p = tadc_parity(w, len8, even);
      if (len8) begin
        return {w[9:2], p, 2'b00};
      end else begin
        return {w, p};
      end
    end
  endfunction

  // -------------------------------------------------------------
  // transmit sequencer
  // -------------------------------------------------------------
  assign frame_new = tadc_frame(hold_ff, sq[`TADC_SI_LEN8],
                                sq[`TADC_SI_EVEN]);

  // the request is edge taken, so a long high pulse starts one frame
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_state_ff <= tadc_pkg::TX_IDLE;
    end else begin
      case (tx_state_ff)
        tadc_pkg::TX_IDLE: begin
          if (rise[`TADC_SI_XMIT] && avail_ff) begin
            tx_state_ff <= tadc_pkg::TX_ARM;
          end
        end
        tadc_pkg::TX_ARM: begin
          if (xr) begin
            tx_state_ff <= tadc_pkg::TX_SEND;
          end
        end
        tadc_pkg::TX_SEND: begin
          if (tx_end) begin
            tx_state_ff <= tadc_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state_ff <= tadc_pkg::TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_ff <= `TADC_RST_FRAME;
      left_ff <= `TADC_RST_LEFT;
    end else if (tx_state_ff == tadc_pkg::TX_ARM && xr) begin
      frame_ff <= frame_new;
      left_ff <= sq[`TADC_SI_LEN8] ? `TADC_BITS_SHORT
                                   : `TADC_BITS_LONG;
    end else if (tx_shift) begin
      frame_ff <= {frame_ff[`TADC_FRAME_W-2:0], 1'b0};
      left_ff <= left_ff - 4'h1;
    end
  end

  // the first bit is set up a full clock before its chain pulse rises, each later bit a half clock before
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ser_ff <= 1'b0;
    end else if (tx_state_ff == tadc_pkg::TX_ARM && xr) begin
      ser_ff <= frame_new[`TADC_FRAME_W-1];
    end else if (tx_end) begin
      ser_ff <= 1'b0;
    end else if (tx_shift) begin
      ser_ff <= frame_ff[`TADC_FRAME_W-2];
    end
  end

  // one pulse per bit: high phase of the tx clock after the bit
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chain_ff <= 1'b0;
    end else if (tx_state_ff == tadc_pkg::TX_SEND && xr) begin
      chain_ff <= 1'b1;
    end else if (xf) begin
      chain_ff <= 1'b0;
    end
  end

  // cascade spans one full tx clock, falling edge to falling edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      casc_ff <= 1'b0;
    end else if (tx_end) begin
      casc_ff <= 1'b1;
    end else if (xf) begin
      casc_ff <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // converter core
  // -------------------------------------------------------------
  tadc_dac_if dac_bus ();

  assign dac_bus.shift_rise = rise[`TADC_SI_SHIFT];
  assign dac_bus.ser_bit = sq[`TADC_SI_SDIN];
  assign dac_bus.par_load = sq[`TADC_SI_PLOAD];
  assign dac_bus.strobe = sq[`TADC_SI_STROBE];
  assign dac_bus.code_twos = sq[`TADC_SI_CODE];
  assign dac_bus.invert = sq[`TADC_SI_INV];
  assign dac_bus.par_word = cnt_ff;

  tadc_dac u_dac (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .bus(dac_bus.core)
  );

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign o_track = cnt_ff;
  assign o_ser_out = ser_ff;
  assign o_pulse_chain = chain_ff;
  assign o_data_avail = avail_ff;
  assign o_cascade = casc_ff;
  assign o_dac_pulse = dac_bus.pulse;

endmodule

// ### sim/tadc_rx_model.sv
// serial receiver model clocked by the transmitted pulse chain
`timescale 1ns/1ps
module tadc_rx_model (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, high
  input wire logic i_chain, // pulse chain from transmitter
  input wire logic i_ser, // serial data
  input wire logic i_cascade, // end of frame marker
  output logic [10:0] o_bits, // received frame, last bit at lsb
  output logic [3:0] o_count, // bits received in the frame
  output logic o_done // one cycle at frame end
);
  logic chain_d_ff;
  logic casc_d_ff;
  logic [10:0] sh_ff;
  logic [3:0] cnt_ff;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chain_d_ff <= 1'h0;
      casc_d_ff <= 1'h0;
      sh_ff <= 11'h000;
      cnt_ff <= 4'h0;
      o_bits <= 11'h000;
      o_count <= 4'h0;
      o_done <= 1'h0;
    end else begin
      chain_d_ff <= i_chain;
      casc_d_ff <= i_cascade;
      o_done <= 1'h0;
      if (i_chain && !chain_d_ff) begin
        sh_ff <= {sh_ff[9:0], i_ser};
        cnt_ff <= cnt_ff + 4'h1;
      end
      if (i_cascade && !casc_d_ff) begin
        o_bits <= sh_ff;
        o_count <= cnt_ff;
        o_done <= 1'h1;
        sh_ff <= 11'h000;
        cnt_ff <= 4'h0;
      end
    end
  end
endmodule

// ### sim/tadc_top_chk.sv
// assertion checker on the ports of the tracking converter
`timescale 1ns/1ps
module tadc_top_chk (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // async reset, high
  input wire logic i_up, // count direction
  input wire logic i_len8, // eight bit frame
  input wire logic i_par_load, // core parallel load
  input wire logic i_code_twos, // twos complement coding
  input wire logic i_invert, // pulse inversion
  input wire logic [9:0] o_track, // tracking counter
  input wire logic o_ser_out, // serial data
  input wire logic o_pulse_chain, // receiver clock
  input wire logic o_data_avail, // data available
  input wire logic o_cascade, // cascade enable
  input wire logic o_dac_pulse // stochastic pulse
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic chain_d_ff;
  logic inv_d_ff;
  logic [3:0] rises_ff;
  logic [3:0] quiet_ff;
  // --------------------
  // helper logic
  // --------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      chain_d_ff <= 1'h0;
      inv_d_ff <= 1'h0;
    end else begin
      chain_d_ff <= o_pulse_chain;
      inv_d_ff <= i_invert;
    end
  end
  // chain pulses in the current frame
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst || !o_data_avail) begin
      rises_ff <= 4'h0;
    end else if (o_pulse_chain && !chain_d_ff) begin
      rises_ff <= rises_ff + 4'h1;
    end
  end
  // cycles of zero word with binary coding and steady invert
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst || !i_par_load || i_code_twos || o_track != 10'h000
        || i_invert != inv_d_ff) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'h8) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  sequence frame_end;
    o_data_avail ##1 (!o_data_avail && o_cascade);
  endsequence
  sequence cascade_hold;
    o_cascade [*8] ##1 !o_cascade;
  endsequence
  a_track_step: assert property ($changed(o_track) |->
    o_track == $past(o_track) + 10'h001 || o_track == $past(o_track) - 10'h001)
    else $error("tracking counter moved by more than one");
  a_track_dir: assert property ($changed(o_track) |->
    (o_track == $past(o_track) + 10'h001) == $past(i_up, 4))
    else $error("tracking counter stepped against direction");
  a_no_wrap: assert property (
    !($past(o_track) == 10'h3FF && o_track == 10'h000)
    && !($past(o_track) == 10'h000 && o_track == 10'h3FF))
    else $error("tracking counter wrapped");
  a_chain_avail: assert property (o_pulse_chain |-> o_data_avail)
    else $error("chain pulse without data");
  a_line_idle: assert property (!o_data_avail |-> !o_ser_out)
    else $error("serial line busy without data");
  a_cascade_len: assert property (frame_end |-> cascade_hold)
    else $error("cascade not one transmitter clock");
  a_chain_count: assert property ($rose(o_cascade) |->
    rises_ff == (i_len8 ? 4'h9 : 4'hB))
    else $error("wrong number of chain pulses");
  a_dac_level: assert property (quiet_ff == 4'h8 |->
    o_dac_pulse == i_invert)
    else $error("pulse level wrong for zero word");
endmodule

// ### sim/testbench.sv
// self-checking bench of the tracking converter
`timescale 1ns/1ps
module testbench;
  logic i_clk = 1'h0, i_rst = 1'h1, i_cnt_clk = 1'h0, i_up = 1'h1;
  logic i_load = 1'h0, i_xmit = 1'h0, i_tx_clk = 1'h0, i_even_par = 1'h0;
  logic i_len8 = 1'h0, i_shift_clk = 1'h1, i_par_load = 1'h1;
  logic i_strobe = 1'h0, i_ser_din = 1'h0, i_code_twos = 1'h0;
  logic i_invert = 1'h0;
  logic [9:0] o_track;
  logic o_ser_out, o_pulse_chain, o_data_avail, o_cascade, o_dac_pulse;
  logic [10:0] rx_bits;
  logic [3:0] rx_count;
  logic rx_done;
  logic [14:0] exp_q[$];
  logic [14:0] note;
  logic [9:0] trk = 10'h000;
  logic [31:0] seed = 32'hE058AACA;
  int errors = 0;
  int checks = 0;
  always #20 i_clk = ~i_clk;
  always #160 i_tx_clk = ~i_tx_clk;
  tadc_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_cnt_clk(i_cnt_clk),
    .i_up(i_up), .i_load(i_load), .i_xmit(i_xmit), .i_tx_clk(i_tx_clk),
    .i_even_par(i_even_par), .i_len8(i_len8), .i_shift_clk(i_shift_clk),
    .i_par_load(i_par_load), .i_strobe(i_strobe), .i_ser_din(i_ser_din),
    .i_code_twos(i_code_twos), .i_invert(i_invert), .o_track(o_track),
    .o_ser_out(o_ser_out), .o_pulse_chain(o_pulse_chain),
    .o_data_avail(o_data_avail), .o_cascade(o_cascade),
    .o_dac_pulse(o_dac_pulse));
  tadc_rx_model rx (.i_clk(i_clk), .i_rst(i_rst), .i_chain(o_pulse_chain),
    .i_ser(o_ser_out), .i_cascade(o_cascade), .o_bits(rx_bits),
    .o_count(rx_count), .o_done(rx_done));
  // --------------------
  // helpers
  // --------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [10:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic await(input logic casc, input int lim);
    int i;
    i = 0;
    while ((casc ? o_cascade : o_data_avail) !== 1'h1) begin
      cyc(1);
      i++;
      if (i == lim) begin
        errors++;
        $display("wrong value wait expected 1 seen 0");
        print_verdict();
      end
    end
  endtask
  task automatic count(input logic up, input int n);
    int k;
    k = (up !== i_up) ? n - 1 : n;
    i_up <= up;
    repeat (n) begin
      cyc(4);
      i_cnt_clk <= 1'h1;
      cyc(4);
      i_cnt_clk <= 1'h0;
    end
    cyc(6);
    repeat (k) begin
      if (up && trk != 10'h3FF) trk = trk + 10'h001;
      if (!up && trk != 10'h000) trk = trk - 10'h001;
    end
    chk("track", {1'h0, trk}, {1'h0, o_track});
  endtask
  task automatic dac_all(input logic [9:0] w);
    int c;
    logic [10:0] e;
    for (int m = 0; m < 4; m++) begin
      i_code_twos <= m[0];
      i_invert <= m[1];
      cyc(12);
      c = 0;
      repeat (1024) begin
        cyc(1);
        c += (o_dac_pulse === 1'h1) ? 1 : 0;
      end
      e = {1'h0, w ^ {m[0], 9'h000}};
      e = m[1] ? 11'h400 - e : e;
      chk("pulse duty", e, 11'(c));
    end
  endtask
  task automatic shift_in(input logic [9:0] w, input logic strb);
    for (int b = 9; b >= 0; b--) begin
      i_shift_clk <= 1'h0;
      i_ser_din <= w[b];
      cyc(4);
      i_shift_clk <= 1'h1;
      cyc(4);
    end
    i_ser_din <= ~w[0];
    i_strobe <= strb;
    cyc(8);
    i_strobe <= 1'h0;
    cyc(4);
  endtask
  task automatic frame(input logic l8, input logic ev, input logic mid);
    logic [9:0] d;
    d = l8 ? {2'h0, trk[9:2]} : trk;
    i_len8 <= l8;
    i_even_par <= ev;
    i_load <= 1'h1;
    cyc(2);
    i_load <= 1'h0;
    exp_q.push_back({l8 ? 4'h9 : 4'hB, d, ^d ^ ~ev});
    await(1'h0, 20);
    i_xmit <= 1'h1;
    cyc(16);
    i_xmit <= 1'h0;
    if (mid) begin
      cyc(20);
      i_load <= 1'h1;
      cyc(2);
      i_load <= 1'h0;
    end
    await(1'h1, 300);
    cyc(3);
    chk("data avail", {10'h0, mid}, {10'h0, o_data_avail});
    cyc(10);
  endtask
  always @(posedge i_clk) begin
    if (rx_done === 1'h1) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 15'h7FFF;
      chk("frame length", {7'h0, note[14:11]}, {7'h0, rx_count});
      chk("frame bits", note[10:0], rx_bits);
    end
  end
  initial begin
    logic [9:0] w;
    cyc(20);
    i_rst <= 1'h0;
    cyc(4);
    dac_all(10'h000);
    $display("end of test zero word");
    count(1'h0, 3);
    count(1'h1, 1030);
    count(1'h0, 5 + rnd() % 200);
    count(1'h1, 1 + rnd() % 40);
    $display("end of test tracking");
    dac_all(trk);
    $display("end of test parallel word");
    for (int m = 0; m < 4; m++) frame(m[0], m[1], m == 3);
    frame(1'h0, 1'h1, 1'h0);
    i_xmit <= 1'h1;
    cyc(16);
    i_xmit <= 1'h0;
    cyc(150);
    $display("end of test transmit");
    w = 10'(rnd());
    i_par_load <= 1'h0;
    shift_in(w, 1'h1);
    shift_in(~w, 1'h0);
    dac_all(w);
    $display("end of test serial word");
    chk("pending frames", 11'h000, 11'(exp_q.size()));
    print_verdict();
  end
endmodule
bind tadc_top tadc_top_chk chk_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_up(i_up), .i_len8(i_len8),
  .i_par_load(i_par_load), .i_code_twos(i_code_twos), .i_invert(i_invert),
  .o_track(o_track), .o_ser_out(o_ser_out), .o_pulse_chain(o_pulse_chain),
  .o_data_avail(o_data_avail), .o_cascade(o_cascade),
  .o_dac_pulse(o_dac_pulse)
);
